/* File: verilog/ecrw_consts.svh */
// Purpose: Shared constants for the ECC register command block
// Assumes: Included by bare name from every design file that needs it
// Notes: Opcodes, field positions, reset values and frame counts
`ifndef ECRW_CONSTS_SVH
`define ECRW_CONSTS_SVH

// Instruction codes
`define ECRW_OP_CLEAR 8'hb6
`define ECRW_OP_WRITE 8'hb5
`define ECRW_OP_READ 8'hb3
`define ECRW_OP_WRITE_ENABLE_CMD 8'h06

// Register layout
`define ECRW_REG_W 48
`define ECRW_DIS_BIT 0
`define ECRW_REG_RST 48'h000000000000

// Frame counting
`define ECRW_BYTES_OPC 2'h1
`define ECRW_BYTES_DATA 2'h2
`define ECRW_BYTES_MAX 2'h3
`define ECRW_STEP_SPI 3'h1
`define ECRW_STEP_QPI 3'h4

// Pin sample reset: chip select idles high
`define ECRW_PINS_RST 6'h10

`endif

/* File: verilog/ecrw_pkg.sv */
// Purpose: Types for the ECC register command block
// Assumes: Constants come from ecrw_consts.svh
// Notes: Pin sample struct and frame phase enumeration
`default_nettype none

package ecrw_pkg;

	// One sample of the serial link pins
	typedef struct packed {
		logic sck;
		logic ce_n;
		logic [3:0] io;
	} ecrw_pins_s;

	// Position inside a chip-select frame
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_CMD,
		PH_ARG,
		PH_READ
	} ecrw_phase_e;

endpackage

`default_nettype wire

/* File: verilog/ecrw_sync.sv */
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs are asynchronous to CLK_IN
// Notes: Output changes only when the second and third stages agree
`timescale 1ns/1ps
`default_nettype none

module ecrw_sync #(
	parameter int W = 6,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Data
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] q_r;
	logic [W-1:0] agree;

	// Bits where the last two stages match may pass
	assign agree = ~(s2_r ^ s3_r);

	// First stage feeds only the second stage
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
			q_r <= RST_VAL;
		end
		else
		begin
			s1_r <= d_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_r <= (s3_r & agree) | (q_r & ~agree);
		end
	end

	assign q_out = q_r;

endmodule

`default_nettype wire

/* File: verilog/ecrw_top.sv */
// Purpose: ECC register command handling behind the serial flash pins
// Assumes: SCK well below CLK_IN/8 so every edge is seen after sampling
// Notes: Sticky error bits are set by the correction engine on ERR_SET_IN
`timescale 1ns/1ps
`default_nettype none
`include "ecrw_consts.svh"

// Functional notes
// - Clear instruction zeroes bits 47..1 and keeps the disable bit.
// - A set status bit stays set until a clear instruction runs.
// - Write instruction loads bit 0; one disables correction, zero enables it.
// - Written data above bit 0 is ignored; host sends one data byte.
// - Write instruction needs a prior accepted write enable, else rejected.
// - Register update starts when chip select rises after a valid write frame.
// - Read instruction shifts out 48 bits from bit 7, wrapping after byte six.
// - Accepted write enable command sets the write enable latch.
module ecrw_top (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	// Serial link pins
	input wire logic SCK_IN,
	input wire logic CE_N_IN,
	input wire logic [3:0] IO_IN,
	output logic [3:0] IO_OUT,
	output logic [3:0] IO_OE_OUT,
	// Mode and correction engine
	input wire logic QUAD_PERIPHERAL_MODE_IN,
	input wire logic [47:1] ERR_SET_IN,
	// Register state
	output logic [47:0] ECC_REG_OUT,
	output logic CORRECTION_DISABLE_BIT_OUT,
	output logic WRITE_ENABLE_LATCH_OUT
);
	import ecrw_pkg::*;

	logic rst_a_r;
	logic rst_n_r;
	ecrw_pkg::ecrw_pins_s pins_raw;
	ecrw_pkg::ecrw_pins_s pins;
	ecrw_pkg::ecrw_pins_s prev_r;
	ecrw_phase_e phase_r;
	logic quad_r;
	logic [2:0] cnt_r;
	logic [1:0] byte_r;
	logic [7:0] sh_r;
	logic [7:0] opcode_r;
	logic data_bit_r;
	logic wel_r;
	logic [47:0] ecc_r;
	logic [47:0] rd_sr_r;
	logic [3:0] io_q_r;
	logic [3:0] oe_r;

	// Two-flop reset release
	always_ff @(posedge CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			rst_a_r <= 1'b0;
			rst_n_r <= 1'b0;
		end
		else
		begin
			rst_a_r <= 1'b1;
			rst_n_r <= rst_a_r;
		end
	end

	// Pins come from the host's clock domain
	assign pins_raw = '{sck: SCK_IN, ce_n: CE_N_IN, io: IO_IN};

	ecrw_sync #(
		.W(6),
		.RST_VAL(`ECRW_PINS_RST)
	) u_sync (
		.clk_in(CLK_IN),
		.rst_n_in(rst_n_r),
		.d_in(pins_raw),
		.q_out(pins)
	);

	// Edge decode on filtered pins
	wire sck_rise = pins.sck & ~prev_r.sck & ~pins.ce_n;
	wire sck_fall = ~pins.sck & prev_r.sck & ~pins.ce_n;
	wire cs_fall = ~pins.ce_n & prev_r.ce_n;
	wire cs_rise = pins.ce_n & ~prev_r.ce_n;

	// Bit carrying differs only in lane count between modes
	wire [2:0] step = quad_r ? `ECRW_STEP_QPI : `ECRW_STEP_SPI;
	wire [7:0] sh_nxt = quad_r ? {sh_r[3:0], pins.io} : {sh_r[6:0], pins.io[0]};
	wire [2:0] cnt_nxt = cnt_r + step;
	wire byte_done = sck_rise && (phase_r != PH_IDLE) && (cnt_nxt == 3'h0);
	wire opc_done = byte_done && (byte_r == 2'h0);
	wire data_done = byte_done && (byte_r == `ECRW_BYTES_OPC);
	wire [1:0] byte_nxt = (byte_r == `ECRW_BYTES_MAX) ? byte_r : byte_r + 2'h1;

	// Frame end decode; partial bytes fail the alignment check
	wire aligned = (cnt_r == 3'h0);
	wire exec_write_enable_cmd = cs_rise && aligned && (byte_r == `ECRW_BYTES_OPC)
		&& (opcode_r == `ECRW_OP_WRITE_ENABLE_CMD);
	wire exec_clear = cs_rise && aligned && (byte_r == `ECRW_BYTES_OPC)
		&& (opcode_r == `ECRW_OP_CLEAR);
	wire exec_write = cs_rise && aligned && (byte_r >= `ECRW_BYTES_DATA)
		&& (opcode_r == `ECRW_OP_WRITE) && wel_r;

	// Read image: byte 0 leaves first, each byte MSB first
	logic [47:0] rd_load;
	always_comb
	begin
		rd_load = '0;
		for (int i = 0; i < 6; i++)
			rd_load[47 - 8 * i -: 8] = ecc_r[8 * i +: 8];
	end
	wire [47:0] rd_rot = quad_r ? {rd_sr_r[43:0], rd_sr_r[47:44]}
		: {rd_sr_r[46:0], rd_sr_r[47]};

	// Frame tracking and input shifting
	always_ff @(posedge CLK_IN or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			prev_r <= `ECRW_PINS_RST;
			phase_r <= PH_IDLE;
			quad_r <= 1'b0;
			cnt_r <= 3'h0;
			byte_r <= 2'h0;
			sh_r <= 8'h00;
			opcode_r <= 8'h00;
			data_bit_r <= 1'b0;
		end
		else
		begin
			prev_r <= pins;
			if (cs_fall)
			begin
				phase_r <= PH_CMD;
				quad_r <= QUAD_PERIPHERAL_MODE_IN;
				cnt_r <= 3'h0;
				byte_r <= 2'h0;
			end
			else if (cs_rise)
				phase_r <= PH_IDLE;
			else if (sck_rise && phase_r != PH_IDLE)
			begin
				sh_r <= sh_nxt;
				cnt_r <= cnt_nxt;
				if (byte_done)
					byte_r <= byte_nxt;
				if (opc_done)
				begin
					opcode_r <= sh_nxt;
					phase_r <= (sh_nxt == `ECRW_OP_READ) ? PH_READ : PH_ARG;
				end
				if (data_done)
					data_bit_r <= sh_nxt[`ECRW_DIS_BIT];
			end
		end
	end

	// Write enable latch, consumed by an executed write
	always_ff @(posedge CLK_IN or negedge rst_n_r)
	begin
		if (!rst_n_r)
			wel_r <= 1'b0;
		else if (exec_write_enable_cmd)
			wel_r <= 1'b1;
		else if (exec_write)
			wel_r <= 1'b0;
	end

	// Status bits: a new error beats a clear in the same cycle
	always_ff @(posedge CLK_IN or negedge rst_n_r)
	begin
		if (!rst_n_r)
			ecc_r <= `ECRW_REG_RST;
		else
		begin
			ecc_r[47:1] <= (exec_clear ? 47'h0 : ecc_r[47:1]) | ERR_SET_IN;
			if (exec_write)
				ecc_r[`ECRW_DIS_BIT] <= data_bit_r;
		end
	end

	// Read shifter drives on falling SCK so data is stable at the host's rise
	always_ff @(posedge CLK_IN or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			rd_sr_r <= 48'h0;
			io_q_r <= 4'h0;
			oe_r <= 4'h0;
		end
		else if (cs_rise || cs_fall)
			oe_r <= 4'h0;
		else if (opc_done)
			rd_sr_r <= rd_load;
		else if (sck_fall && phase_r == PH_READ)
		begin
			io_q_r <= quad_r ? rd_sr_r[47:44] : {2'h0, rd_sr_r[47], 1'b0};
			oe_r <= quad_r ? 4'hf : 4'h2;
			rd_sr_r <= rd_rot;
		end
	end

	// Outputs
	assign IO_OUT = io_q_r;
	assign IO_OE_OUT = oe_r;
	assign ECC_REG_OUT = ecc_r;
	assign CORRECTION_DISABLE_BIT_OUT = ecc_r[`ECRW_DIS_BIT];
	assign WRITE_ENABLE_LATCH_OUT = wel_r;

	// Checks tied to the command effects
	a_clear_zeroes: assert property (@(posedge CLK_IN) disable iff (!rst_n_r)
		exec_clear |=> (ecc_r[47:1] == $past(ERR_SET_IN)) && (ecc_r[0] == $past(ecc_r[0])))
		else $error("Clear did not zero status bits");

	a_sticky_hold: assert property (@(posedge CLK_IN) disable iff (!rst_n_r)
		!exec_clear |=> ((ecc_r[47:1] & $past(ecc_r[47:1])) == $past(ecc_r[47:1])))
		else $error("Status bit dropped without clear");

	a_write_loads: assert property (@(posedge CLK_IN) disable iff (!rst_n_r)
		exec_write |=> (ecc_r[0] == $past(data_bit_r)))
		else $error("Write did not load disable bit");

	a_upper_ignored: assert property (@(posedge CLK_IN) disable iff (!rst_n_r)
		(exec_write && !exec_clear) |=>
			(ecc_r[47:1] == ($past(ecc_r[47:1]) | $past(ERR_SET_IN))))
		else $error("Write touched status bits");

	a_needs_wel: assert property (@(posedge CLK_IN) disable iff (!rst_n_r)
		(cs_rise && opcode_r == `ECRW_OP_WRITE && !wel_r) |=> $stable(ecc_r[0]))
		else $error("Write accepted without write enable");

	a_update_at_rise: assert property (@(posedge CLK_IN) disable iff (!rst_n_r)
		!$stable(ecc_r[0]) |-> $past(cs_rise) && $past(opcode_r) == `ECRW_OP_WRITE)
		else $error("Disable bit changed outside frame end");

	a_wel_sets: assert property (@(posedge CLK_IN) disable iff (!rst_n_r)
		exec_write_enable_cmd |=> wel_r ##1 (wel_r || $past(exec_write)))
		else $error("Write enable latch not set");

	a_short_frame: assert property (@(posedge CLK_IN) disable iff (!rst_n_r)
		(cs_rise && (cnt_r != 3'h0 || byte_r < `ECRW_BYTES_DATA)) |-> !exec_write)
		else $error("Short write frame executed");

	a_read_wrap: assert property (@(posedge CLK_IN) disable iff (!rst_n_r)
		(sck_fall && phase_r == PH_READ && !quad_r) |=> (rd_sr_r == {$past(rd_sr_r[46:0]),
			$past(rd_sr_r[47])}) && (io_q_r[1] == $past(rd_sr_r[47])))
		else $error("Read shifter did not rotate");

	a_quad_lanes: assert property (@(posedge CLK_IN) disable iff (!rst_n_r)
		(sck_rise && phase_r != PH_IDLE && quad_r) |=> (sh_r[3:0] == $past(pins.io)))
		else $error("Quad lanes not shifted together");

endmodule

`default_nettype wire

/* File: verification/ecrw_host.sv */
// Purpose: Host controller model for the serial link
// Assumes: clk_in is the bench clock; SCK halves last six clocks
// Notes: Lanes the host does not drive toggle, so stale values never match
`timescale 1ns/1ps
`default_nettype none

module ecrw_host (
	// Clock and mode
	input wire logic clk_in,
	input wire logic quad_in,
	// Link
	input wire logic [3:0] io_in,
	output logic sck_out,
	output logic ce_n_out,
	output logic [3:0] io_out
);
	// Idle link: SCK low, chip select high
	initial
	begin
		sck_out = 1'b0;
		ce_n_out = 1'b1;
		io_out = 4'h5;
	end

	// While chip select is high, all lanes invert every cycle instead of holding a stale level
	always @(posedge clk_in)
	begin
		if (ce_n_out)
			io_out <= ~io_out;
	end

	// One frame, MSB first; rx collects lane 1 (all lanes in quad) at each SCK rise
	task automatic xfer(input logic [63:0] tx, input int nbits, output logic [63:0] rx);
		int step;
		step = quad_in ? 4 : 1;
		rx = '0;
		@(negedge clk_in);
		ce_n_out = 1'b0;
		repeat (6) @(negedge clk_in);
		for (int i = 0; i < nbits; i += step)
		begin
			io_out = quad_in ? tx[63-i -: 4] : {~io_out[3:1], tx[63-i]};
			repeat (6) @(negedge clk_in);
			sck_out = 1'b1;
			rx = quad_in ? {rx[59:0], io_in} : {rx[62:0], io_in[1]};
			repeat (6) @(negedge clk_in);
			sck_out = 1'b0;
		end
		// Chip select rises only after the last bit is latched
		repeat (6) @(negedge clk_in);
		ce_n_out = 1'b1;
		repeat (8) @(negedge clk_in);
	endtask
endmodule

`default_nettype wire

/* File: verification/test_ecc_register_clear_write.sv */
// Purpose: Self-checking bench for the ECC register command block
// Assumes: Host model drives the link; bench drives the rest
// Notes: Each scenario is one task; opcodes come from the constants, expected values are literals
`timescale 1ns/1ps
`default_nettype none
`include "ecrw_consts.svh"

module test_ecc_register_clear_write;
	logic clk, resetn, quad, sck, ce_n;
	logic [47:1] err;
	logic [3:0] io_q, io_oe, host_io, io_wire;
	logic [47:0] ecc_reg;
	logic dis_bit, write_enable_latch;
	logic [63:0] rx;
	int n_mismatch = 0;
	int n_compared = 0;

	// Lane level: device wins where it drives, host elsewhere
	assign io_wire = (io_oe & io_q) | (~io_oe & host_io);

	ecrw_top i_ecrw_top (.CLK_IN(clk), .RESETN_IN(resetn), .SCK_IN(sck), .CE_N_IN(ce_n),
		.IO_IN(io_wire), .IO_OUT(io_q), .IO_OE_OUT(io_oe), .QUAD_PERIPHERAL_MODE_IN(quad),
		.ERR_SET_IN(err), .ECC_REG_OUT(ecc_reg), .CORRECTION_DISABLE_BIT_OUT(dis_bit),
		.WRITE_ENABLE_LATCH_OUT(write_enable_latch));

	ecrw_host i_ecrw_host (.clk_in(clk), .quad_in(quad), .io_in(io_wire), .sck_out(sck),
		.ce_n_out(ce_n), .io_out(host_io));

	// 40 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic frame(input logic [7:0] op, input logic [7:0] d, input int n);
		i_ecrw_host.xfer({op, d, 48'h0}, n, rx);
	endtask

	// One-cycle set request from the correction engine
	task automatic pulse(input logic [47:1] m);
		@(negedge clk);
		err = m;
		@(negedge clk);
		err = '0;
		@(negedge clk);
	endtask

	task automatic t_reset;
		check(64'(ecc_reg), 64'h0);
		check(64'(write_enable_latch), 64'h0);
		check(64'(io_oe), 64'h0);
	endtask

	// Write without enable, then a short frame, both leave the register
	task automatic t_refuse;
		frame(`ECRW_OP_WRITE, 8'hff, 16);
		check(64'(ecc_reg), 64'h0);
		frame(`ECRW_OP_WRITE_ENABLE_CMD, 8'h00, 8);
		check(64'(write_enable_latch), 64'h1);
		frame(`ECRW_OP_WRITE, 8'hff, 15);
		check(64'(ecc_reg), 64'h0);
	endtask

	// FFh must touch bit 0 only
	task automatic t_write;
		frame(`ECRW_OP_WRITE, 8'hff, 16);
		check(64'(ecc_reg), 64'h1);
		check(64'(dis_bit), 64'h1);
		check(64'(write_enable_latch), 64'h0);
	endtask

	task automatic t_sticky;
		pulse(47'h400000000010);
		frame(`ECRW_OP_WRITE_ENABLE_CMD, 8'h00, 8);
		frame(`ECRW_OP_WRITE, 8'h00, 16);
		check(64'(ecc_reg), 64'h800000000020);
		frame(`ECRW_OP_WRITE_ENABLE_CMD, 8'h00, 8);
		frame(`ECRW_OP_WRITE, 8'hff, 16);
		check(64'(ecc_reg), 64'h800000000021);
		frame(`ECRW_OP_CLEAR, 8'h00, 8);
		check(64'(ecc_reg), 64'h1);
	endtask

	// 56 bits after the opcode: six bytes, then byte 0 again
	task automatic t_read;
		logic [47:0] r;
		r = 48'h010000000201;
		pulse(47'h008000000100);
		check(64'(ecc_reg), 64'(r));
		frame(`ECRW_OP_READ, 8'h00, 64);
		check({8'h0, rx[55:0]}, {8'h0, r[7:0], r[15:8], r[23:16], r[31:24],
			r[39:32], r[47:40], r[7:0]});
		check(64'(io_oe), 64'h0);
	endtask

	// Same commands over four lanes
	task automatic t_quad;
		@(negedge clk);
		quad = 1'b1;
		repeat (4) @(negedge clk);
		frame(`ECRW_OP_WRITE_ENABLE_CMD, 8'h00, 8);
		frame(`ECRW_OP_WRITE, 8'h00, 16);
		check(64'(ecc_reg), 64'h010000000200);
		// Quad read: opcode nibbles, then twelve data nibbles, byte 0 first
		frame(`ECRW_OP_READ, 8'h00, 56);
		check({16'h0, rx[47:0]}, 64'h0000000200000001);
		check(64'(io_oe), 64'h0);
		frame(`ECRW_OP_CLEAR, 8'h00, 8);
		check(64'(ecc_reg), 64'h0);
	endtask

	// Main sequence
	initial
	begin
		resetn = 1'b0;
		quad = 1'b0;
		err = '0;
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		repeat (10) @(negedge clk);
		t_reset();
		t_refuse();
		t_write();
		t_sticky();
		t_read();
		t_quad();
		print_verdict();
	end

	// Watchdog: the run needs about 2700 clocks
	initial
	begin
		repeat (16000) @(posedge clk);
		n_mismatch++;
		print_verdict();
	end
endmodule

`default_nettype wire
